// ==== src/ccs_clutch.sv ====
`timescale 1ns/10ps
module ccs_clutch
    import ccs_pkg::*;
#(
    parameter int LEAD_W = 32,
    parameter int POS_W  = 32
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Master axis and triggers
    input  wire ccs_pulse_t        master_pulse,
    input  wire logic              discrete_input,
    input  wire logic              capture_done,
    input  wire logic              disengage_req,
    // Cam profile drive
    output ccs_pulse_t             profile_step,
    output ccs_state_t             clutch_state,
    output logic                   overflow_trip
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    ccs_ctrl_t                 ctrl;
    ccs_state_t                state;
    logic signed [LEAD_W-1:0]  lead_count;
    logic signed [LEAD_W-1:0]  first_lead;
    logic signed [LEAD_W-1:0]  reengage_lead;
    logic [POS_W-1:0]          profile_pos;
    logic                      apb_access;
    logic                      apb_wr;
    logic                      engage_cond;
    logic                      disengage_cond;
    logic                      count_step;
    logic                      count_zero;
    logic                      count_overflow;
    logic signed [LEAD_W-1:0]  next_lead;
    logic signed [LEAD_W-1:0]  away_lead;

    // Zero-count check shared by both entries into countdown
    function automatic logic is_zero(input logic signed [LEAD_W-1:0] v);
        return (v == '0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    assign apb_access = psel && penable;
    assign apb_wr     = apb_access && pwrite;

    ccs_apb_regs #(
        .LEAD_W        (LEAD_W)
    ) u_regs (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .wr_first      (apb_wr && (paddr == REG_FIRST_LEAD)),
        .wr_reengage   (apb_wr && (paddr == REG_REENGAGE_LEAD)),
        .wdata         (pwdata),
        .first_lead    (first_lead),
        .reengage_lead (reengage_lead)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !(paddr == REG_CTRL || paddr == REG_FIRST_LEAD ||
                         paddr == REG_REENGAGE_LEAD || paddr == REG_STATUS ||
                         paddr == REG_LEAD_MONITOR || paddr == REG_PROFILE_POS);
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_CTRL:          prdata <= {20'h00000, ctrl.dis_sel, ctrl.eng_sel,
                                              3'h0, ctrl.enable};
                REG_FIRST_LEAD:    prdata <= 32'(first_lead);
                REG_REENGAGE_LEAD: prdata <= 32'(reengage_lead);
                REG_STATUS:        prdata <= {28'h0000000, overflow_trip, state};
                REG_LEAD_MONITOR:  prdata <= 32'(lead_count);
                REG_PROFILE_POS:   prdata <= 32'(profile_pos);
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= ccs_ctrl_t'(CTRL_RESET[8:0]);
        end else if (state == CCS_LEAD && count_overflow) begin
            ctrl.enable <= CAM_DISABLED;
        end else if (apb_wr && paddr == REG_CTRL) begin
            ctrl.enable  <= pwdata[CTRL_EN_BIT];
            ctrl.eng_sel <= pwdata[CTRL_ENG_LSB +: 4];
            ctrl.dis_sel <= pwdata[CTRL_DIS_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger conditions

    always_comb begin
        case (ctrl.eng_sel)
            ENG_IMMEDIATE: engage_cond = 1'b1;
            ENG_DISCRETE:  engage_cond = discrete_input;
            ENG_CAPTURE:   engage_cond = capture_done;
            default:       engage_cond = 1'b0;
        endcase
    end

    always_comb begin
        case (ctrl.dis_sel)
            DIS_DISCRETE_OFF: disengage_cond = !discrete_input;
            DIS_FIXED_PULSES: disengage_cond = disengage_req;
            DIS_REENGAGE:     disengage_cond = disengage_req;
            DIS_EXTERNAL:     disengage_cond = disengage_req;
            default:          disengage_cond = 1'b0;
        endcase
    end

    // A pulse counts toward engagement only in the direction of the sign
    assign count_step     = master_pulse.step &&
                            (master_pulse.dir_neg == lead_count[LEAD_W-1]);
    assign next_lead      = lead_count[LEAD_W-1] ? lead_count + 2'sd1
                                                 : lead_count - 2'sd1;
    // Wrong-direction pulses move the count away from zero
    assign away_lead      = lead_count[LEAD_W-1] ? lead_count - 2'sd1
                                                 : lead_count + 2'sd1;
    assign count_zero     = count_step && is_zero(next_lead);
    // Wrong-direction pulses push magnitude away; trip at the limit
    assign count_overflow = master_pulse.step && !count_step &&
                            (lead_count[LEAD_W-1] ?
                             (lead_count == {1'b1, {(LEAD_W-1){1'b0}}}) :
                             (lead_count == {1'b0, {(LEAD_W-1){1'b1}}}));

    ////////////////////////////////////////////////////////////////////////
    // Clutch state machine

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= CCS_STOP;
        end else if (ctrl.enable == CAM_DISABLED) begin
            state <= CCS_STOP;
        end else begin
            case (state)
                CCS_STOP: begin
                    if (engage_cond) begin
                        state <= is_zero(first_lead) ? CCS_ENGAGED : CCS_LEAD;
                    end
                end
                CCS_LEAD: begin
                    if (count_overflow) begin
                        state <= CCS_STOP;
                    end else if (count_zero || is_zero(lead_count)) begin
                        state <= CCS_ENGAGED;
                    end
                end
                CCS_ENGAGED: begin
                    if (disengage_cond && ctrl.dis_sel == DIS_REENGAGE) begin
                        state <= is_zero(reengage_lead) ? CCS_ENGAGED
                                                        : CCS_LEAD;
                    end else if (disengage_cond) begin
                        state <= CCS_STOP;
                    end
                end
                default: state <= CCS_STOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lead pulse counter

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lead_count <= '0;
        end else if (ctrl.enable == CAM_DISABLED) begin
            lead_count <= '0;
        end else if (state == CCS_STOP && engage_cond) begin
            lead_count <= first_lead;
        end else if (state == CCS_ENGAGED && disengage_cond &&
                     ctrl.dis_sel == DIS_REENGAGE) begin
            lead_count <= reengage_lead;
        end else if (state == CCS_LEAD && master_pulse.step && !count_overflow) begin
            lead_count <= count_step ? next_lead : away_lead;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cam profile follower

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            profile_step <= '0;
        end else begin
            profile_step.step    <= master_pulse.step && state == CCS_ENGAGED
                                    && ctrl.enable == CAM_ENABLED;
            profile_step.dir_neg <= master_pulse.dir_neg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            profile_pos <= '0;
        end else if (master_pulse.step && state == CCS_ENGAGED &&
                     ctrl.enable == CAM_ENABLED) begin
            profile_pos <= master_pulse.dir_neg ? profile_pos - POS_W'(1)
                                                : profile_pos + POS_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clutch_state <= CCS_STOP;
        end else begin
            clutch_state <= state;
        end
    end

    // Sticky until software enables again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overflow_trip <= 1'b0;
        end else if (state == CCS_LEAD && count_overflow) begin
            overflow_trip <= 1'b1;
        end else if (apb_wr && paddr == REG_CTRL && pwdata[CTRL_EN_BIT]) begin
            overflow_trip <= 1'b0;
        end
    end

endmodule

// ==== src/ccs_pkg.sv ====
package ccs_pkg;

    // Enable field values
    localparam logic       CAM_DISABLED      = 1'h0;
    localparam logic       CAM_ENABLED       = 1'h1;

    // Engage selector encodings
    localparam logic [3:0] ENG_IMMEDIATE     = 4'h0;
    localparam logic [3:0] ENG_DISCRETE      = 4'h1;
    localparam logic [3:0] ENG_CAPTURE       = 4'h2;

    // Disengage selector encodings
    localparam logic [3:0] DIS_NONE          = 4'h0;
    localparam logic [3:0] DIS_DISCRETE_OFF  = 4'h1;
    localparam logic [3:0] DIS_FIXED_PULSES  = 4'h2;
    localparam logic [3:0] DIS_REENGAGE      = 4'h4;
    localparam logic [3:0] DIS_EXTERNAL      = 4'h6;

    // Discrete input function code for the clutch
    localparam logic [7:0] CLUTCH_DI_CODE    = 8'h36;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL          = 8'h00;
    localparam logic [7:0] REG_FIRST_LEAD    = 8'h04;
    localparam logic [7:0] REG_REENGAGE_LEAD = 8'h08;
    localparam logic [7:0] REG_STATUS        = 8'h0C;
    localparam logic [7:0] REG_LEAD_MONITOR  = 8'h10;
    localparam logic [7:0] REG_PROFILE_POS   = 8'h14;

    // Control register field positions
    localparam int         CTRL_EN_BIT       = 0;
    localparam int         CTRL_ENG_LSB      = 4;
    localparam int         CTRL_DIS_LSB      = 8;

    // Reset values
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] LEAD_RESET       = 32'h0000_0000;

    // Clutch states, one-hot
    typedef enum logic [2:0] {
        CCS_STOP    = 3'b001,
        CCS_LEAD    = 3'b010,
        CCS_ENGAGED = 3'b100
    } ccs_state_t;

    // Master pulse event with direction
    typedef struct packed {
        logic step;
        logic dir_neg;
    } ccs_pulse_t;

    // Control fields
    typedef struct packed {
        logic [3:0] dis_sel;
        logic [3:0] eng_sel;
        logic       enable;
    } ccs_ctrl_t;

endpackage

// ==== src/ccs_apb_regs.sv ====
`timescale 1ns/10ps
// Small register store: two signed lead counts, each loaded from wdata on its own write strobe
module ccs_apb_regs
    import ccs_pkg::*;
#(
    parameter int LEAD_W = 32
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Write port
    input  wire logic              wr_first,
    input  wire logic              wr_reengage,
    input  wire logic [31:0]       wdata,
    // Stored values
    output logic signed [LEAD_W-1:0] first_lead,
    output logic signed [LEAD_W-1:0] reengage_lead
);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            first_lead <= LEAD_RESET[LEAD_W-1:0];
        end else if (wr_first) begin
            first_lead <= wdata[LEAD_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reengage_lead <= LEAD_RESET[LEAD_W-1:0];
        end else if (wr_reengage) begin
            reengage_lead <= wdata[LEAD_W-1:0];
        end
    end

endmodule

// ==== dv/ccs_clutch_monitor.sv ====
`timescale 1ns/10ps
module ccs_clutch_monitor
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Axis side
    input wire ccs_pulse_t  master_pulse,
    input wire logic        discrete_input,
    input wire logic        capture_done,
    input wire logic        disengage_req,
    input wire ccs_pulse_t  profile_step,
    input wire ccs_state_t  clutch_state,
    input wire logic        overflow_trip
);
    ccs_ctrl_t ctrl;
    logic      reeng_nz;
    logic      wr;
    logic      arm;
    logic      eng;
    assign wr  = psel && penable && pready && pwrite;
    assign arm = ctrl.enable && !overflow_trip;
    assign eng = clutch_state == CCS_ENGAGED;
    ////////////////////////////////////////
    // Shadow of the control fields
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
        end else if (wr && paddr == REG_CTRL) begin
            ctrl <= {pwdata[11:8], pwdata[7:4], pwdata[0]};
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reeng_nz <= 1'b0;
        end else if (wr && paddr == REG_REENGAGE_LEAD) begin
            reeng_nz <= |pwdata;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_stop_at(c);
        c ##1 clutch_state == CCS_STOP;
    endsequence
    sequence s_eng_at(c);
        c ##1 eng;
    endsequence
    property p_one_hot;
        $onehot(clutch_state);
    endproperty
    property p_idle_quiet;
        !eng [*3] |-> !$past(profile_step.step);
    endproperty
    property p_follow;
        master_pulse.step && eng ##1 eng [*2] |-> $past(profile_step.step)
            && $past(profile_step.dir_neg) == $past(master_pulse.dir_neg, 2);
    endproperty
    property p_trip;
        $rose(overflow_trip) |-> $past(master_pulse.step) ##[0:2] clutch_state == CCS_STOP;
    endproperty
    property p_disable;
        wr && paddr == REG_CTRL && !pwdata[CTRL_EN_BIT] |-> ##[1:3] clutch_state == CCS_STOP;
    endproperty
    property p_engage_imm;
        s_stop_at(arm && ctrl.eng_sel == ENG_IMMEDIATE) |=> clutch_state != CCS_STOP;
    endproperty
    property p_engage_di;
        s_stop_at(arm && ctrl.eng_sel == ENG_DISCRETE && discrete_input)
            |=> clutch_state != CCS_STOP;
    endproperty
    property p_engage_cap;
        s_stop_at(arm && ctrl.eng_sel == ENG_CAPTURE && capture_done)
            |=> clutch_state != CCS_STOP;
    endproperty
    property p_dis_ext;
        s_eng_at(disengage_req && ctrl.dis_sel == DIS_EXTERNAL) |=> clutch_state == CCS_STOP;
    endproperty
    property p_reengage;
        s_eng_at(arm && disengage_req && ctrl.dis_sel == DIS_REENGAGE && reeng_nz)
            |=> clutch_state == CCS_LEAD;
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("state not one-hot");
    a_idle_quiet: assert property (p_idle_quiet) else $error("step while idle");
    a_follow: assert property (p_follow) else $error("engaged step lost");
    a_trip: assert property (p_trip) else $error("bad overflow trip");
    a_disable: assert property (p_disable) else $error("disable ignored");
    a_engage_imm: assert property (p_engage_imm) else $error("no engage");
    a_engage_di: assert property (p_engage_di) else $error("no input engage");
    a_engage_cap: assert property (p_engage_cap) else $error("capture late");
    a_dis_ext: assert property (p_dis_ext) else $error("no disengage");
    a_reengage: assert property (p_reengage) else $error("no re-entry");
endmodule
bind ccs_clutch ccs_clutch_monitor u_mon (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .master_pulse(master_pulse),
    .discrete_input(discrete_input), .capture_done(capture_done),
    .disengage_req(disengage_req), .profile_step(profile_step),
    .clutch_state(clutch_state), .overflow_trip(overflow_trip)
);

// ==== dv/ccs_master_model.sv ====
`timescale 1ns/10ps
module ccs_master_model
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Requests
    input  wire logic       start,
    input  wire logic [7:0] n,
    input  wire logic       dir_neg,
    input  wire logic       slow,
    input  wire logic       cap_req,
    // Far side outputs
    output ccs_pulse_t      master_pulse,
    output logic            capture_done,
    output logic            busy
);
    logic [7:0] left;
    logic [1:0] gap;
    assign busy = left != 8'h00;
    // Counts out n pulses, spaced 2 or 4 cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            left <= 8'h00;
            gap  <= 2'h0;
        end else if (start) begin
            left <= n;
            gap  <= 2'h0;
        end else if (busy && gap == 2'h0) begin
            left <= left - 8'h01;
            gap  <= slow ? 2'h3 : 2'h1;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end
    end
    // Direction only meaningful with a step, toggles otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            master_pulse <= '0;
            capture_done <= 1'b0;
        end else begin
            master_pulse.step    <= busy && gap == 2'h0 && !start;
            master_pulse.dir_neg <= (busy && gap == 2'h0) ? dir_neg : ~master_pulse.dir_neg;
            capture_done         <= cap_req;
        end
    end
endmodule

// ==== dv/test_ccs_clutch.sv ====
`timescale 1ns/10ps
module test_ccs_clutch;
    import ccs_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        di      = 1'b0;
    logic        dis_req = 1'b0;
    logic        m_start = 1'b0;
    logic [7:0]  m_n     = 8'h00;
    logic        m_dir   = 1'b0;
    logic        m_slow  = 1'b0;
    logic        m_cap   = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        m_busy;
    logic        cap_done;
    logic        bus_err;
    logic [31:0] rdat;
    ccs_pulse_t  pulse;
    ccs_pulse_t  prof;
    ccs_state_t  state;
    logic        trip;
    int          n_errors = 0;
    int          checked  = 0;
    always #12.5 sys_clk = ~sys_clk;
    ccs_master_model u_master (.sys_clk(sys_clk), .rst(rst), .start(m_start), .n(m_n),
        .dir_neg(m_dir), .slow(m_slow), .cap_req(m_cap), .master_pulse(pulse),
        .capture_done(cap_done), .busy(m_busy));
    ccs_clutch #(.LEAD_W(4)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_pulse(pulse),
        .discrete_input(di), .capture_done(cap_done), .disengage_req(dis_req),
        .profile_step(prof), .clutch_state(state), .overflow_trip(trip));
    ////////////////////////////////////////
    task final_report;
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task hang;
        n_errors++;
        $display("unexpected at %0t: wait timed out", $time);
        final_report();
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) hang();
        rdat    = prdata;
        bus_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rdat, exp);
    endtask
    task st(input ccs_state_t s);
        repeat (4) @(posedge sys_clk);
        cmp({29'h0, state}, {29'h0, s});
        rd(REG_STATUS, {29'h0, s});
    endtask
    task pulses(input logic [7:0] n, input logic dir, input logic slow);
        int i;
        @(posedge sys_clk);
        m_n     <= n;
        m_dir   <= dir;
        m_slow  <= slow;
        m_start <= 1'b1;
        @(posedge sys_clk);
        m_start <= 1'b0;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (m_busy !== 1'b0 && i < 100);
        if (m_busy !== 1'b0) hang();
    endtask
    task kick(input logic cap);
        @(posedge sys_clk);
        if (cap) m_cap <= 1'b1;
        else dis_req <= 1'b1;
        @(posedge sys_clk);
        m_cap   <= 1'b0;
        dis_req <= 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(REG_CTRL, 32'h0);
        st(CCS_STOP);
        rd(REG_LEAD_MONITOR, 32'h0);
        pulses(8'h03, 1'b0, 1'b0);
        rd(REG_PROFILE_POS, 32'h0);
        wr(REG_FIRST_LEAD, 32'h3);
        wr(REG_CTRL, 32'h001);
        st(CCS_LEAD);
        rd(REG_LEAD_MONITOR, 32'h3);
        pulses(8'h02, 1'b0, 1'b0);
        rd(REG_LEAD_MONITOR, 32'h1);
        rd(REG_PROFILE_POS, 32'h0);
        pulses(8'h01, 1'b0, 1'b0);
        st(CCS_ENGAGED);
        pulses(8'h04, 1'b0, 1'b1);
        rd(REG_PROFILE_POS, 32'h4);
        wr(REG_REENGAGE_LEAD, 32'h2);
        wr(REG_CTRL, 32'h401);
        st(CCS_ENGAGED);
        kick(1'b0);
        st(CCS_LEAD);
        rd(REG_LEAD_MONITOR, 32'h2);
        pulses(8'h02, 1'b0, 1'b0);
        st(CCS_ENGAGED);
        wr(REG_CTRL, 32'h000);
        st(CCS_STOP);
        wr(REG_FIRST_LEAD, 32'h0);
        wr(REG_CTRL, 32'h111);
        st(CCS_STOP);
        di <= 1'b1;
        st(CCS_ENGAGED);
        di <= 1'b0;
        st(CCS_STOP);
        wr(REG_CTRL, 32'h611);
        di <= 1'b1;
        st(CCS_ENGAGED);
        di <= 1'b0;
        st(CCS_ENGAGED);
        kick(1'b0);
        st(CCS_STOP);
        wr(REG_CTRL, 32'h021);
        st(CCS_STOP);
        kick(1'b1);
        st(CCS_ENGAGED);
        wr(REG_CTRL, 32'h000);
        wr(REG_FIRST_LEAD, 32'hFFFF_FFFE);
        wr(REG_CTRL, 32'h001);
        st(CCS_LEAD);
        pulses(8'h02, 1'b1, 1'b1);
        st(CCS_ENGAGED);
        wr(REG_CTRL, 32'h000);
        wr(REG_FIRST_LEAD, 32'h3);
        wr(REG_CTRL, 32'h001);
        pulses(8'h08, 1'b1, 1'b0);
        rd(REG_STATUS, 32'h9);
        rd(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h001);
        st(CCS_LEAD);
        apb(1'b0, 8'h40, 32'h0);
        cmp({31'h0, bus_err}, 32'h1);
        final_report();
    end
endmodule
